// ---- rtl/ssr_pkg.sv ----
// Shared constants of the serial status read-back block: selection codes,
// word layout, write-word field positions and reset values.
// Assumes a 16-bit serial frame from a host that drives the serial clock.
package ssr_pkg;

  // ------------------------------------------------------------------
  // Frame geometry
  // ------------------------------------------------------------------
  localparam int unsigned FRAME_BITS = 16;       // Bits in one frame
  localparam logic [4:0] FRAME_CNT_FULL = 5'h10; // Count at a complete frame
  localparam logic [4:0] FRAME_CNT_MAX = 5'h1F;  // Counter saturates here

  // ------------------------------------------------------------------
  // Selection codes (also the code field of each returned word)
  // ------------------------------------------------------------------
  localparam logic [3:0] SEL_DEFAULT = 4'h0;     // Maps onto the quick word
  localparam logic [3:0] SEL_QUICK = 4'h1;
  localparam logic [3:0] SEL_CH1 = 4'h2;
  localparam logic [3:0] SEL_CH2 = 4'h3;
  localparam logic [3:0] SEL_CH3 = 4'h4;
  localparam logic [3:0] SEL_CH4 = 4'h5;
  localparam logic [3:0] SEL_DEVICE = 4'h7;
  localparam logic [3:0] SEL_LIVE_IO = 4'h8;
  localparam logic [3:0] SEL_PART_ID = 4'h9;

  // ------------------------------------------------------------------
  // Incoming word layout (first initialization register)
  // ------------------------------------------------------------------
  localparam logic [3:0] INIT1_ADDR = 4'h0;      // Write address in bits 15..12
  localparam int unsigned WR_ADDR_LSB = 12;
  localparam int unsigned WR_SEL_LSB = 0;        // so_address_select 3..0
  localparam int unsigned WR_HOLD_BIT = 4;       // so_address_hold
  localparam int unsigned WR_FB_LSB = 5;         // feedback_select 7..5

  // ------------------------------------------------------------------
  // Outgoing word layout
  // ------------------------------------------------------------------
  localparam int unsigned CODE_LSB = 12;         // Selection code 15..12
  localparam int unsigned FAIL_BIT = 11;         // fail_mode_ind
  localparam int unsigned OC_NONE_W = 3;         // Width of overcurrent_code
  localparam logic [2:0] OC_NONE = 3'h0;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [3:0] SEL_RESET = SEL_DEFAULT;
  localparam logic HOLD_RESET = 1'b0;
  localparam logic [2:0] FB_RESET = 3'h0;
  localparam logic RCF_RESET = 1'b1;             // Registers were just cleared

endpackage : ssr_pkg

// ---- rtl/ssr_sync.sv ----
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes each bit is an independent level; no bus coherence is promised.
module ssr_sync #(
  parameter int unsigned W = 1,              // Number of bits
  parameter logic [W-1:0] INIT = '0          // Value held under reset
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] meta;                      // First stage, read only by second
    logic [W-1:0] stable;                    // Second stage, safe to use
  } ssr_sync_type;

  ssr_sync_type s_q;
  ssr_sync_type s_d;

  // Next state: plain shift through both stages
  always_comb begin
    s_d = s_q;
    s_d.meta = async_in;
    s_d.stable = s_q.meta;
  end

  // Registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_q <= {INIT, INIT};
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;

endmodule : ssr_sync

// ---- rtl/ssr_status_readout.sv ----
// Serial status read-back of a four-channel high-side switch.
// Assumes: serial pins come straight from the host and are resynchronised here;
// fault events and mode levels come from on-chip logic on mclk.
module ssr_status_readout
  import ssr_pkg::*;
#(
  parameter logic [7:0] PART_ID = 8'h5A     // Arbitrary value, not a real part code
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic sclk,                     // Serial clock pin
  input wire logic csb_n,                    // Chip select pin, low in frame
  input wire logic si,                       // Serial data in
  output logic so,                           // Serial data out
  output logic so_oe,                        // Serial out driven while selected
  input wire logic fail_mode,                // Device is in fail mode
  input wire logic sleep_mode,               // Device is in sleep mode
  input wire logic [3:0] ots_evt,            // Overtemp shutdown per channel
  input wire logic [3:0] otw_evt,            // Overtemp warning per channel
  input wire logic [3:0] oc_evt,             // Overcurrent event per channel
  input wire logic [11:0] oc_code_in,        // Three bits per channel
  input wire logic [3:0] olon_evt,           // Open load while on
  input wire logic [3:0] oloff_evt,          // Open load while off
  input wire logic uv_evt,                   // Undervoltage
  input wire logic ov_evt,                   // Overvoltage
  input wire logic pump_evt,                 // Charge pump fault
  input wire logic clk_fail_evt,             // Clock fail
  input wire logic test_mode_evt,            // Test mode entered
  input wire logic serial_fail_evt,          // Serial fail from watchdog logic
  input wire logic limp_pin,                 // Deglitched limp-home input
  input wire logic [3:0] input_pins,         // Deglitched control inputs
  input wire logic [3:0] toggle_pins,        // Input toggle signals
  input wire logic [3:0] out_cmp_pins,       // Output comparators at half battery
  output logic sense_feedback_en,            // Analog feedback enabled
  output logic [2:0] sense_feedback_sel      // Analog feedback source
);

  // ------------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------------
  logic [2:0] link_s;                        // {csb_n, sclk, si} resynchronised
  logic [12:0] live_s;                       // {limp, inputs, toggles, comparators}

  ssr_sync #(.W(3), .INIT(3'h4)) u_link_sync (
    .mclk(mclk),
    .rstn(rstn),
    .async_in({csb_n, sclk, si}),
    .sync_out(link_s)
  );

  ssr_sync #(.W(13), .INIT(13'h0000)) u_live_sync (
    .mclk(mclk),
    .rstn(rstn),
    .async_in({limp_pin, input_pins, toggle_pins, out_cmp_pins}),
    .sync_out(live_s)
  );

  logic csb_s;
  logic sclk_s;
  logic si_s;
  assign csb_s = link_s[2];
  assign sclk_s = link_s[1];
  assign si_s = link_s[0];

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic csb_p;                             // Previous chip select
    logic sclk_p;                            // Previous serial clock
    logic [15:0] tx;                         // Outgoing shift register
    logic [15:0] rx;                         // Incoming shift register
    logic [4:0] cnt;                         // Rising edges in this frame
    logic [3:0] sel;                         // so_address_select in force
    logic hold;                              // so_address_hold
    logic [3:0] word_sel;                    // Selection loaded this frame
    logic [3:0] ots;
    logic [3:0] otw;
    logic [11:0] oc;                         // overcurrent_code per channel
    logic [3:0] olon;
    logic [3:0] oloff;
    logic test_mode_flag;
    logic ovf;
    logic undervoltage_flag;
    logic serial_fail_flag;
    logic pump_fault;
    logic clock_fail_flag;
    logic regs_cleared_flag;
    logic so;
    logic so_oe;
    logic fb_en;
    logic [2:0] fb_sel;                      // feedback_select as written
    logic [2:0] fb_out;                      // Source handed to the multiplexer
  } ssr_state_type;

  ssr_state_type s_q;
  ssr_state_type s_d;

  // ------------------------------------------------------------------
  // Link edges and frame decode
  // ------------------------------------------------------------------
  logic sclk_rise;
  logic sclk_fall;
  logic sof;                                 // Frame start
  logic eof;                                 // Frame end
  logic good_frame;                          // Frame end with exactly 16 bits
  logic wr_init;                             // Good frame writing init register
  assign sclk_rise = sclk_s & ~s_q.sclk_p & ~csb_s;
  assign sclk_fall = ~sclk_s & s_q.sclk_p & ~csb_s;
  assign sof = ~csb_s & s_q.csb_p;
  assign eof = csb_s & ~s_q.csb_p;
  assign good_frame = eof && (s_q.cnt == FRAME_CNT_FULL);
  assign wr_init = good_frame && (s_q.rx[WR_ADDR_LSB +: 4] == INIT1_ADDR);

  // ------------------------------------------------------------------
  // Summaries and per-channel words
  // ------------------------------------------------------------------
  logic [3:0] qsf;                           // channel_quick_flag
  logic [3:0] ch_ovl;                        // Per-channel overload term
  logic [15:0] ch_word [4];                  // Channel status words
  logic device_fault_summary;
  logic overload_summary;
  logic openload_summary;
  logic [3:0] common;                        // Bits 11..8 of latched words

  for (genvar i = 0; i < 4; i++) begin : g_ch
    // Quick flag: any overcurrent code, thermal or open-load latch
    assign qsf[i] = (s_q.oc[3*i +: 3] != OC_NONE) | s_q.otw[i] | s_q.ots[i] |
                    s_q.olon[i] | s_q.oloff[i];
    assign ch_ovl[i] = (s_q.oc[3*i +: 3] != OC_NONE) | s_q.ots[i];
    // Code, common bits, reserved, OTS, OTW, OC code, OLON, OLOFF
    assign ch_word[i] = {4'(SEL_CH1 + 4'(i)), common, 1'b0, s_q.ots[i], s_q.otw[i],
                         s_q.oc[3*i +: 3], s_q.olon[i], s_q.oloff[i]};
  end

  // Summaries are pure functions of the latches, so they fall on their own
  // once every latch behind them has been read away.
  assign device_fault_summary = s_q.regs_cleared_flag | s_q.undervoltage_flag | s_q.ovf | s_q.pump_fault | s_q.clock_fail_flag | s_q.test_mode_flag;
  assign overload_summary = |ch_ovl;
  assign openload_summary = |(s_q.olon | s_q.oloff);
  assign common = {fail_mode, device_fault_summary, overload_summary, openload_summary};

  // ------------------------------------------------------------------
  // Outgoing word multiplexer
  // ------------------------------------------------------------------
  logic [15:0] word;
  logic [7:0] id_bits;
  assign id_bits = s_q.undervoltage_flag ? 8'h00 : PART_ID;

  // Unlisted codes fall back to the quick word so the host never sees junk
  always_comb begin
    unique case (s_q.sel)
      SEL_CH1: word = ch_word[0];
      SEL_CH2: word = ch_word[1];
      SEL_CH3: word = ch_word[2];
      SEL_CH4: word = ch_word[3];
      SEL_DEVICE: begin
        word = {SEL_DEVICE, common, 3'h0, s_q.test_mode_flag, s_q.ovf, s_q.undervoltage_flag, s_q.serial_fail_flag,
                live_s[12]};
      end
      SEL_LIVE_IO: begin
        // Comparator bits pass through even in undervoltage; host must ignore them
        word = {SEL_LIVE_IO, fail_mode, 1'b0, |live_s[7:4], live_s[11:8], 1'b0,
                live_s[3:0]};
      end
      SEL_PART_ID: word = {SEL_PART_ID, 4'h0, id_bits};
      default: begin
        word = {SEL_QUICK, common, s_q.pump_fault, s_q.regs_cleared_flag, s_q.clock_fail_flag, 1'b0, qsf};
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    logic clr_dev;
    logic [3:0] clr_ch;
    clr_dev = good_frame && (s_q.word_sel == SEL_DEVICE);
    for (int k = 0; k < 4; k++) begin
      clr_ch[k] = good_frame && (s_q.word_sel == 4'(SEL_CH1 + 4'(k)));
    end
    s_d = s_q;
    s_d.csb_p = csb_s;
    s_d.sclk_p = sclk_s;

    // Frame start: load the word chosen by the previous frame, MSB first
    if (sof) begin
      s_d.tx = {word[14:0], 1'b0};
      s_d.so = word[15];
      s_d.word_sel = s_q.sel;
      s_d.cnt = 5'h00;
      s_d.so_oe = 1'b1;
    end else if (sclk_fall) begin
      // Output moves on the falling edge so the host samples on the rising one
      s_d.so = s_q.tx[15];
      s_d.tx = {s_q.tx[14:0], 1'b0};
    end
    // Input sampled on the rising edge, counter stops at its ceiling
    if (sclk_rise) begin
      s_d.rx = {s_q.rx[14:0], si_s};
      if (s_q.cnt != FRAME_CNT_MAX) begin
        s_d.cnt = 5'(s_q.cnt + 5'h01);
      end
    end

    // Frame end: release the pin, then decide the next selection
    if (eof) begin
      s_d.so_oe = 1'b0;
      if (wr_init) begin
        s_d.sel = s_q.rx[WR_SEL_LSB +: 4];
        s_d.hold = s_q.rx[WR_HOLD_BIT];
        s_d.fb_sel = s_q.rx[WR_FB_LSB +: 3];
      end else if (good_frame && !s_q.hold) begin
        s_d.sel = SEL_DEFAULT;
      end
    end

    // Channel latches: a new event beats the read that would clear it
    for (int k = 0; k < 4; k++) begin
      s_d.ots[k] = (s_q.ots[k] & ~clr_ch[k]) | ots_evt[k];
      s_d.otw[k] = (s_q.otw[k] & ~clr_ch[k]) | otw_evt[k];
      s_d.olon[k] = (s_q.olon[k] & ~clr_ch[k]) | olon_evt[k];
      s_d.oloff[k] = (s_q.oloff[k] & ~clr_ch[k]) | oloff_evt[k];
      if (oc_evt[k]) begin
        s_d.oc[3*k +: 3] = oc_code_in[3*k +: 3];
      end else if (clr_ch[k]) begin
        s_d.oc[3*k +: 3] = OC_NONE;
      end
    end

    // Device latches, cleared by reading the device word
    s_d.undervoltage_flag = (s_q.undervoltage_flag & ~clr_dev) | uv_evt;
    s_d.ovf = (s_q.ovf & ~clr_dev) | ov_evt;
    s_d.test_mode_flag = (s_q.test_mode_flag & ~clr_dev) | test_mode_evt;
    s_d.pump_fault = (s_q.pump_fault & ~clr_dev) | pump_evt;
    s_d.clock_fail_flag = (s_q.clock_fail_flag & ~clr_dev) | clk_fail_evt;
    s_d.regs_cleared_flag = s_q.regs_cleared_flag & ~clr_dev;
    // A frame of the wrong length is itself a serial fault
    s_d.serial_fail_flag = (s_q.serial_fail_flag & ~clr_dev) | serial_fail_evt | (eof && !good_frame);

    // Analog feedback only in normal mode
    s_d.fb_en = ~fail_mode & ~sleep_mode;
    s_d.fb_out = s_q.fb_sel;
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.csb_p <= 1'b1;
      s_q.sel <= SEL_RESET;
      s_q.hold <= HOLD_RESET;
      s_q.fb_sel <= FB_RESET;
      s_q.fb_out <= FB_RESET;
      s_q.regs_cleared_flag <= RCF_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign so = s_q.so;
  assign so_oe = s_q.so_oe;
  assign sense_feedback_en = s_q.fb_en;
  assign sense_feedback_sel = s_q.fb_out;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_read_only_end;
    good_frame && !wr_init;
  endsequence

  sequence s_frame_load;
    sof;
  endsequence

  property p_sel_write;
    wr_init |=> s_q.sel == $past(s_q.rx[3:0]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("selection not taken");

  property p_one_shot;
    s_read_only_end and !s_q.hold |=> s_q.sel == SEL_DEFAULT;
  endproperty
  a_one_shot: assert property (p_one_shot) else $error("one-shot did not revert");

  property p_hold;
    s_read_only_end and s_q.hold |=> $stable(s_q.sel);
  endproperty
  a_hold: assert property (p_hold) else $error("held selection changed");

  property p_load_bit;
    s_frame_load |=> so == $past(word[15]);
  endproperty
  a_load_bit: assert property (p_load_bit) else $error("first bit not word MSB");

  property p_code_field;
    (s_q.sel == SEL_DEFAULT) |-> word[15:12] == SEL_QUICK && word[FAIL_BIT] == fail_mode;
  endproperty
  a_code_field: assert property (p_code_field) else $error("code zero not quick");

  property p_dsf_set;
    uv_evt |=> device_fault_summary && s_q.undervoltage_flag;
  endproperty
  a_dsf_set: assert property (p_dsf_set) else $error("summary missed undervoltage");

  // A stuck enable would leave the line driven between frames
  property p_oe_release;
    eof |=> !so_oe;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("output not released");

  property p_olon_clear;
    good_frame && s_q.word_sel == SEL_CH1 && !olon_evt[0] |=> !s_q.olon[0] && !openload_summary ||
                                                              (|s_q.olon[3:1]) ||
                                                              (|s_q.oloff);
  endproperty
  a_olon_clear: assert property (p_olon_clear) else $error("open load not cleared");

  property p_oc_latest;
    oc_evt[0] |=> s_q.oc[2:0] == $past(oc_code_in[2:0]);
  endproperty
  a_oc_latest: assert property (p_oc_latest) else $error("overcurrent code stale");

  property p_id_uv;
    s_q.undervoltage_flag && s_q.sel == SEL_PART_ID |-> word[7:0] == 8'h00;
  endproperty
  a_id_uv: assert property (p_id_uv) else $error("part id shown in undervoltage");

  property p_fb_mode;
    (fail_mode || sleep_mode) |=> !sense_feedback_en;
  endproperty
  a_fb_mode: assert property (p_fb_mode) else $error("feedback on outside normal");

endmodule : ssr_status_readout

// ---- sim/ssr_host_model.sv ----
// Behavioural host acting as serial master on the status link.
// Assumes mode 0 framing, a 160 ns bit time, and that the bench resolves
// the device's serial output line before it reaches so_in.
module ssr_host_model (
  output logic sclk,
  output logic csb_n,
  output logic si,
  input wire logic so_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------------
  // Idle link: clock stands low, select high
  // ------------------------------------------------------------------
  initial begin
    sclk = 1'b0;
    csb_n = 1'b0 ^ 1'b1;
    si = 1'b0;
  end

  // One frame of n bits, MSB first both ways; n below 16 makes a bad frame
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    int i;
    r = 16'h0000;
    csb_n = 1'b0;
    #160;
    for (i = 0; i < n; i++) begin
      si = w[15-i];
      #80 sclk = 1'b1;
      #80 r[15-i] = so_in;
      sclk = 1'b0;
    end
    #80 csb_n = 1'b1;
    // Released line shows no stale data
    si = ~si;
    // Gap between frames leaves room for the selection update
    #320;
  endtask : xfer
endmodule : ssr_host_model

// ---- sim/tb_spi_status_readout.sv ----
// Self-checking bench of the serial status read-back block.
// Assumes the host model drives the link and events are pulsed on mclk.
module tb_spi_status_readout;
  import ssr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------------
  // Stimulus and observation signals
  // ------------------------------------------------------------------
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic fail_mode = 1'b0;
  logic sleep_mode = 1'b0;
  logic [3:0] ots_evt = 4'h0, otw_evt = 4'h0, oc_evt = 4'h0, olon_evt = 4'h0, oloff_evt = 4'h0;
  logic [11:0] oc_code_in = 12'h000;
  logic uv_evt = 1'b0, ov_evt = 1'b0, pump_evt = 1'b0, clk_fail_evt = 1'b0;
  logic test_mode_evt = 1'b0, serial_fail_evt = 1'b0, limp_pin = 1'b0;
  logic [3:0] input_pins = 4'h0, toggle_pins = 4'h0, out_cmp_pins = 4'h0;
  logic sclk, csb_n, si, so, so_oe, so_w, sense_feedback_en;
  logic [2:0] sense_feedback_sel;
  int n_mismatch = 0;
  int samples_checked = 0;

  // Undriven output line shows the inverse of its last value
  assign so_w = so_oe ? so : ~so;

  ssr_status_readout dut (.mclk(mclk), .rstn(rstn), .sclk(sclk), .csb_n(csb_n), .si(si),
    .so(so), .so_oe(so_oe), .fail_mode(fail_mode), .sleep_mode(sleep_mode),
    .ots_evt(ots_evt), .otw_evt(otw_evt), .oc_evt(oc_evt), .oc_code_in(oc_code_in),
    .olon_evt(olon_evt), .oloff_evt(oloff_evt), .uv_evt(uv_evt), .ov_evt(ov_evt),
    .pump_evt(pump_evt), .clk_fail_evt(clk_fail_evt), .test_mode_evt(test_mode_evt),
    .serial_fail_evt(serial_fail_evt), .limp_pin(limp_pin), .input_pins(input_pins),
    .toggle_pins(toggle_pins), .out_cmp_pins(out_cmp_pins),
    .sense_feedback_en(sense_feedback_en), .sense_feedback_sel(sense_feedback_sel));

  ssr_host_model host (.sclk(sclk), .csb_n(csb_n), .si(si), .so_in(so_w));

  // 50 MHz system clock
  always #10 mclk = ~mclk;

  // ------------------------------------------------------------------
  // Verdict, compares and shared frame task
  // ------------------------------------------------------------------
  task automatic print_verdict;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  // Compare of a returned serial word
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Compare of the feedback enable and source pins
  task automatic chk_fb(input logic [3:0] g, input logic [3:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_fb

  // Full frame sending w and expecting e back
  task automatic fc(input logic [15:0] w, input logic [15:0] e);
    logic [15:0] r;
    host.xfer(w, 16, r);
    chk(r, e);
  endtask : fc

  // Reset held three cycles; link start kept off the clock edge
  task automatic do_reset;
    @(posedge mclk) rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    #7;
  endtask : do_reset

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  // One-shot selection of the device word after reset
  task automatic t_select;
    fc(16'h0007, 16'h1440);
    fc(16'h1000, 16'h7400);
    fc(16'h1000, 16'h1000);
  endtask : t_select

  // Channel 2 latches, latest overcurrent code, held selection
  task automatic t_channel;
    @(posedge mclk) otw_evt <= 4'h2;
    olon_evt <= 4'h2;
    ots_evt <= 4'h2;
    oloff_evt <= 4'h2;
    oc_evt <= 4'h2;
    oc_code_in <= 12'h008;
    @(posedge mclk) {otw_evt, olon_evt, ots_evt, oloff_evt} <= 16'h0000;
    oc_code_in <= 12'h030;
    @(posedge mclk) oc_evt <= 4'h0;
    #7;
    fc(16'h0013, 16'h1302);
    fc(16'h1000, 16'h337B);
    fc(16'h0000, 16'h3000);
    fc(16'h1000, 16'h1000);
  endtask : t_channel

  // Live levels in fail mode, feedback gating and source
  task automatic t_live;
    @(posedge mclk) fail_mode <= 1'b1;
    input_pins <= 4'h5;
    toggle_pins <= 4'h2;
    out_cmp_pins <= 4'hA;
    limp_pin <= 1'b1;
    #7;
    fc(16'h00A8, 16'h1800);
    fc(16'h1000, 16'h8AAA);
    chk_fb({sense_feedback_en, sense_feedback_sel}, 4'h5);
    @(posedge mclk) fail_mode <= 1'b0;
    repeat (4) @(posedge mclk);
    #7;
    chk_fb({sense_feedback_en, sense_feedback_sel}, 4'hD);
    @(posedge mclk) sleep_mode <= 1'b1;
    repeat (4) @(posedge mclk);
    #7;
    chk_fb({sense_feedback_en, sense_feedback_sel}, 4'h5);
    @(posedge mclk) sleep_mode <= 1'b0;
  endtask : t_live

  // Channel 1 and 4 words, an unlisted code and the explicit quick code
  task automatic t_codes;
    @(posedge mclk) olon_evt <= 4'h9;
    oc_evt <= 4'h1;
    oc_code_in <= 12'h004;
    @(posedge mclk) {olon_evt, oc_evt} <= 8'h00;
    #7;
    fc(16'h0012, 16'h1309);
    fc(16'h0005, 16'h2312);
    fc(16'h0006, 16'h5102);
    fc(16'h0001, 16'h1000);
    fc(16'h1000, 16'h1000);
  endtask : t_codes

  // Undervoltage hides the part code until the device word is read
  task automatic t_uv;
    @(posedge mclk) uv_evt <= 1'b1;
    ov_evt <= 1'b1;
    @(posedge mclk) {uv_evt, ov_evt} <= 2'h0;
    #7;
    fc(16'h0009, 16'h1400);
    fc(16'h0007, 16'h9000);
    fc(16'h0009, 16'h740D);
    fc(16'h1000, 16'h905A);
  endtask : t_uv

  // Short frame refused, device faults, host reset on test mode
  task automatic t_refused;
    logic [15:0] r;
    host.xfer(16'h0007, 15, r);
    @(posedge mclk) {test_mode_evt, pump_evt, clk_fail_evt} <= 3'h7;
    @(posedge mclk) {test_mode_evt, pump_evt, clk_fail_evt} <= 3'h0;
    #7;
    fc(16'h0007, 16'h14A0);
    fc(16'h1000, 16'h7413);
    do_reset();
    fc(16'h1000, 16'h1440);
  endtask : t_refused

  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    do_reset();
    t_select();
    t_channel();
    t_live();
    t_uv();
    t_codes();
    t_refused();
    print_verdict();
  end

  // About 20 frames of 3.1 us each; over five times that cuts a hang
  initial begin
    #400000;
    n_mismatch++;
    print_verdict();
  end
endmodule : tb_spi_status_readout
